// [ast_defines.svh]
// Register offsets, field positions, reset values and timing counts of the serial transmitter
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH
`define AST_ADDR_W 4
`define AST_OFF_CTRL 4'h0
`define AST_OFF_RATE 4'h4
`define AST_OFF_DATA 4'h8
`define AST_OFF_STAT 4'hC
`define AST_CTRL_TRANSMIT_ENABLE 0
`define AST_CTRL_SYNC 1
`define AST_CTRL_SERIAL_PORT_ON 2
`define AST_CTRL_POL 3
`define AST_CTRL_BRG16 4
`define AST_CTRL_NINE 5
`define AST_CTRL_D8 6
`define AST_CTRL_IE 7
`define AST_STAT_EMPTY 0
`define AST_STAT_SHIFT 1
`define AST_STAT_DONE 2
`define AST_CTRL_RST 8'h00
`define AST_RATE_RST 16'h0000
`define AST_FLAG_DELAY 2
`endif

// [ast_pkg.sv]
// Types shared by the serial transmitter
package ast_pkg;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [3:0] adr;
      logic [31:0] dat;
   } ast_wb_req_type;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } ast_wb_rsp_type;
   typedef struct packed {
      logic out;
      logic oe;
   } ast_pin_type;
   typedef enum logic [1:0] {AST_IDLE, AST_START, AST_DATA, AST_STOP} ast_state_type;
endpackage

// [ast_baud_gen.sv]
// Baud tick generator dividing the system clock by divisor plus one
`timescale 1ns/1ps
module ast_baud_gen #(
   parameter int DIV_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic wide_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic tick_o
);
   logic [DIV_W-1:0] cnt_q;
   wire [DIV_W-1:0] limit = wide_i ? div_i : {{(DIV_W-8){1'b0}}, div_i[7:0]};
   wire hit = (cnt_q >= limit);
   initial begin
      if (DIV_W < 9) $error("ast_baud_gen needs DIV_W of at least 9");
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i || hit) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
   assign tick_o = run_i && hit;
   // R19 - one tick per period
   chk_tick_single: assert property (@(posedge clk_i) disable iff (rst_i) // R19
      tick_o && limit != '0 |=> !tick_o) else $error("baud tick lasted more than one cycle");
endmodule // ast_baud_gen

// [ast_tx.sv]
// Asynchronous serial transmitter with Wishbone register slave
// Operation
// R1 - NRZ levels, mark while idle
// R2 - Start, eight or nine data, stop
// R3 - Every bit lasts one baud period
// R4 - Generator selectable 8 or 16 bit
// R5 - Data bits sent LSb first
// R6 - No parity; ninth bit from software
// R7 - Shift register hidden, loaded from buffer
// R8 - Software sets enable, async, port on
// R9 - Port on drives pin as output
// R10 - Software clears analog select on pin
// R11 - Empty flag set when enable set
// R12 - Write starts; empty shifter loads immediately
// R13 - Busy shifter: wait, transfer after stop
// R14 - Start bit follows transfer, no gap
// R15 - Polarity bit inverts idle and data
// R16 - Polarity applies in async mode only
// R17 - Empty flag read-only, valid two cycles later
// R18 - Interrupt gated, flag tracks regardless
// R19 - Single-cycle tick, one bit per tick
`timescale 1ns/1ps
`include "ast_defines.svh"
module ast_tx #(
   parameter int DIV_W = 16,
   parameter int FLAG_DELAY = `AST_FLAG_DELAY
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire ast_pkg::ast_wb_req_type wb_req_i,
   output ast_pkg::ast_wb_rsp_type wb_rsp_o,
   output ast_pkg::ast_pin_type pin_o,
   output logic irq_o
);
   import ast_pkg::*;
   initial begin
      if (FLAG_DELAY < 2 || FLAG_DELAY > 8) $error("ast_tx FLAG_DELAY out of range");
      if (DIV_W != 16) $error("ast_tx supports DIV_W of 16 only");
   end

   logic [7:0] ctrl_q;
   logic [15:0] rate_q;
   logic [8:0] hold_q;
   logic hold_full_q;
   logic [8:0] shift_q;
   logic [3:0] bits_q;
   ast_state_type state_q;
   logic [2:0] stat_q;
   logic [2:0] mask_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic [FLAG_DELAY-1:0] wr_hist_q;
   logic line_q;
   logic transmit_enable_prev_q;

   // Bus decode
   wire req = wb_req_i.cyc && wb_req_i.stb && !ack_q;
   wire wr = req && wb_req_i.we;
   wire rd = req && !wb_req_i.we;
   wire lane0 = wb_req_i.sel[0];
   wire hit_ctrl = wb_req_i.adr == `AST_OFF_CTRL;
   wire hit_rate = wb_req_i.adr == `AST_OFF_RATE;
   wire hit_data = wb_req_i.adr == `AST_OFF_DATA;
   wire hit_stat = wb_req_i.adr == `AST_OFF_STAT;
   wire wr_ctrl = wr && hit_ctrl && lane0;
   wire wr_data = wr && hit_data && lane0;
   wire wr_mask = wr && hit_stat && lane0;
   wire rd_stat = rd && hit_stat;

   wire transmit_enable = ctrl_q[`AST_CTRL_TRANSMIT_ENABLE];
   wire sync = ctrl_q[`AST_CTRL_SYNC];
   wire serial_port_on = ctrl_q[`AST_CTRL_SERIAL_PORT_ON];
   wire pol = ctrl_q[`AST_CTRL_POL];
   wire nine = ctrl_q[`AST_CTRL_NINE];
   wire irq_en = ctrl_q[`AST_CTRL_IE];
   // R8 - software selects async
   wire run = transmit_enable && serial_port_on && !sync;

   // R4 - selectable width generator
   logic tick;
   ast_baud_gen #(.DIV_W(DIV_W)) u_baud (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(run && state_q != AST_IDLE),
      .wide_i(ctrl_q[`AST_CTRL_BRG16]),
      .div_i(rate_q),
      .tick_o(tick)
   );

   // R12 - load immediately when idle
   // R13 - pending character after stop
   wire stop_end = (state_q == AST_STOP) && tick;
   wire can_load = (state_q == AST_IDLE) || stop_end;
   wire load = run && hold_full_q && can_load;
   wire frame_done = stop_end && !load;
   wire empty_now = transmit_enable && !hold_full_q;
   // R17 - flag valid after buffer write
   wire empty_flag = empty_now && (wr_hist_q == '0);
   wire transmit_enable_rise = transmit_enable && !transmit_enable_prev_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `AST_CTRL_RST;
         rate_q <= `AST_RATE_RST;
         mask_q <= '0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wb_req_i.dat[7:0];
         end
         if (wr && hit_rate && lane0) begin
            rate_q[7:0] <= wb_req_i.dat[7:0];
         end
         if (wr && hit_rate && wb_req_i.sel[1]) begin
            rate_q[15:8] <= wb_req_i.dat[15:8];
         end
         if (wr_mask) begin
            mask_q <= wb_req_i.dat[2:0];
         end
      end
   end

   // R7 - buffer is the only software path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_q <= '0;
         hold_full_q <= 1'b0;
      end else if (wr_data) begin
         hold_q <= {ctrl_q[`AST_CTRL_D8], wb_req_i.dat[7:0]};
         hold_full_q <= 1'b1;
      end else if (load || !transmit_enable) begin
         hold_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_hist_q <= '0;
         transmit_enable_prev_q <= 1'b0;
      end else begin
         wr_hist_q <= {wr_hist_q[FLAG_DELAY-2:0], wr_data};
         transmit_enable_prev_q <= transmit_enable;
      end
   end

   // R2 - frame sequence
   // R14 - start follows load directly
   always_ff @(posedge clk_i) begin
      if (rst_i || !run) begin
         state_q <= AST_IDLE;
         shift_q <= '0;
         bits_q <= '0;
      end else if (load) begin
         state_q <= AST_START;
         shift_q <= hold_q;
         bits_q <= '0;
      end else if (tick) begin
         case (state_q)
            AST_START: begin
               state_q <= AST_DATA;
            end
            AST_DATA: begin
               // R5 - shift LSb first
               // R19 - one bit per tick
               shift_q <= {1'b0, shift_q[8:1]};
               bits_q <= bits_q + 1'b1;
               // R6 - ninth bit only as supplied
               if (bits_q == (nine ? 4'h8 : 4'h7)) begin
                  state_q <= AST_STOP;
               end
            end
            AST_STOP: begin
               state_q <= AST_IDLE;
            end
            default: begin
               state_q <= AST_IDLE;
            end
         endcase
      end
   end

   // R1 - mark while idle
   // R3 - bit held one period
   wire raw_bit = (state_q == AST_START) ? 1'b0 : (state_q == AST_DATA) ? shift_q[0] : 1'b1;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_q <= 1'b1;
      end else begin
         // R15 - optional inversion
         // R16 - async only
         line_q <= raw_bit ^ (pol && !sync);
      end
   end
   // R9 - port on makes pin an output
   assign pin_o.out = line_q;
   assign pin_o.oe = serial_port_on;

   // Sticky status; set wins over read clear
   // R11 - flag on enable
   wire [2:0] ev = {frame_done, 1'b0, transmit_enable_rise || (empty_flag && !stat_q[`AST_STAT_EMPTY] && empty_now)};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= '0;
      end else if (rd_stat) begin
         stat_q <= ev;
      end else begin
         stat_q <= stat_q | ev;
      end
   end
   // R18 - gated interrupt
   assign irq_o = (irq_en && empty_flag) || |(stat_q & mask_q & 3'b101);

   wire [31:0] rd_mux = hit_ctrl ? {24'h00_0000, ctrl_q} :
      hit_rate ? {16'h0000, rate_q} :
      hit_stat ? {26'h000_0000, mask_q, stat_q[2], (state_q != AST_IDLE), empty_flag} : 32'h0000_0000;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= '0;
      end else begin
         ack_q <= req;
         rdat_q <= rd ? rd_mux : 32'h0000_0000;
      end
   end
   assign wb_rsp_o.ack = ack_q;
   assign wb_rsp_o.dat = rdat_q;

   // R1 - idle line is mark
   chk_idle_mark: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      state_q == AST_IDLE && !pol |=> line_q) else $error("idle line not at mark");
   // R14 - start after load
   chk_start_follow: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      load |=> state_q == AST_START ##1 !line_q ^ (pol && !sync)) else $error("start bit did not follow load");
   // R13 - no load mid frame
   chk_load_boundary: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      load |-> state_q == AST_IDLE || state_q == AST_STOP) else $error("load while frame busy");
   // R12 - idle load at once
   chk_idle_load: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      run && hold_full_q && state_q == AST_IDLE |=> state_q == AST_START) else $error("idle shifter did not load");
   // R11 - enable sets flag
   chk_enable_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      transmit_enable_rise && !rd_stat |=> stat_q[0]) else $error("enable did not set empty status");
   // R17 - flag clear after write
   chk_flag_write: assert property (@(posedge clk_i) disable iff (rst_i) // R17
      wr_data |=> !empty_flag) else $error("empty flag high right after write");
   // R9 - pin direction
   chk_pin_dir: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      $rose(serial_port_on) |-> pin_o.oe) else $error("pin not output with port on");
   // R18 - gating of interrupt
   chk_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R18
      !irq_en && mask_q == 3'b000 |-> !irq_o) else $error("interrupt raised while disabled");
   // R16 - clocked mode no inversion
   chk_sync_pol: assert property (@(posedge clk_i) disable iff (rst_i) // R16
      sync && state_q == AST_IDLE |=> line_q) else $error("inverted in clocked mode");
endmodule // ast_tx

// [ast_rx_model.sv]
// Remote receiver model sampling the serial line
`timescale 1ns/1ps
module ast_rx_model (
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic en_i,
   input wire logic invert_i,
   input wire logic nine_i,
   input wire logic [15:0] period_i,
   output logic [8:0] data_o,
   output int frames_o,
   output int gap_o,
   output int bad_o
);
   int cyc = 0;
   int last = 0;
   logic [8:0] sh;
   initial begin
      data_o = '0;
      frames_o = 0;
      gap_o = 0;
      bad_o = 0;
   end
   always @(posedge clk_i) cyc <= cyc + 1;
   always begin
      @(posedge clk_i);
      if (en_i && (line_i ^ invert_i) == 1'b0) begin
         gap_o = cyc - last;
         last = cyc;
         repeat (period_i / 2) @(posedge clk_i);
         if ((line_i ^ invert_i) !== 1'b0) bad_o++;
         sh = '0;
         for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
            repeat (period_i) @(posedge clk_i);
            sh[i] = line_i ^ invert_i;
         end
         repeat (period_i) @(posedge clk_i);
         if ((line_i ^ invert_i) !== 1'b1) bad_o++;
         data_o = sh;
         frames_o++;
      end
   end
endmodule // ast_rx_model

// [testbench.sv]
// Self-checking bench for the serial transmitter
`timescale 1ns/1ps
module testbench;
   import ast_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   ast_wb_req_type req = '0;
   ast_wb_rsp_type rsp;
   ast_pin_type pin;
   logic irq;
   logic en = 1'b0;
   logic inv = 1'b0;
   logic nine = 1'b0;
   logic [15:0] per = 16'h0004;
   logic [8:0] rx;
   logic [31:0] rd;
   int frames;
   int gap;
   int bad;
   int failures = 0;
   int checks = 0;
   // Line pulled up while undriven
   wire logic line = pin.oe ? pin.out : 1'b1;
   always #12.5 clk_i = ~clk_i;
   ast_tx dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .pin_o(pin), .irq_o(irq));
   ast_rx_model rx_u (.clk_i(clk_i), .line_i(line), .en_i(en), .invert_i(inv), .nine_i(nine),
      .period_i(per), .data_o(rx), .frames_o(frames), .gap_o(gap), .bad_o(bad));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int n;
      n = 0;
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      rd = rsp.dat;
      req <= '0;
      @(posedge clk_i);
      if (n >= 50) begin
         failures++;
         results();
      end
   endtask
   task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, dat, 4'b0001);
   endtask
   task automatic rdc(input string name, input logic [3:0] adr, input logic [31:0] m, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0000_0000, 4'b0011);
      chk(name, exp, rd & m);
   endtask
   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (frames < n && k < 6000) begin
         @(posedge clk_i);
         k++;
      end
      if (frames < n) begin
         failures++;
         results();
      end
   endtask
   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("idle line", 32'h1, {31'h0, pin.out});
      chk("pin enable", 32'h0, {31'h0, pin.oe});
      rdc("ctrl", 4'h0, 32'h0000_00FF, 32'h0);
      rdc("rate", 4'h4, 32'h0000_FFFF, 32'h0);
      rdc("unmapped", 4'h2, 32'hFFFF_FFFF, 32'h0);
      $display("test reset done");
      wb(1'b1, 4'h4, 32'h0000_0103, 4'b0011);
      wr(4'h0, 32'h0000_0005);
      chk("pin enable", 32'h1, {31'h0, pin.oe});
      rdc("empty flag", 4'hC, 32'h1, 32'h1);
      en <= 1'b1;
      wr(4'h8, 32'h0000_00A5);
      wr(4'h8, 32'h0000_003C);
      rdc("buffer state", 4'hC, 32'h3, 32'h2);
      wait_frames(1);
      chk("first char", 32'hA5, {23'h0, rx});
      wait_frames(2);
      chk("second char", 32'h3C, {23'h0, rx});
      chk("start spacing", 32'd40, 32'(gap));
      $display("test queued pair done");
      rdc("sticky done", 4'hC, 32'h4, 32'h4);
      rdc("sticky clear", 4'hC, 32'h4, 32'h0);
      wr(4'h8, 32'h0000_005A);
      wait_frames(3);
      repeat (8) @(posedge clk_i);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(4'hC, 32'h0000_0004);
      chk("irq raised", 32'h1, {31'h0, irq});
      rdc("sticky done", 4'hC, 32'h4, 32'h4);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(4'h0, 32'h0000_0085);
      chk("empty irq", 32'h1, {31'h0, irq});
      $display("test interrupt done");
      nine <= 1'b1;
      wr(4'h0, 32'h0000_0065);
      wr(4'h8, 32'h0000_0001);
      wait_frames(4);
      chk("nine bit char", 32'h101, {23'h0, rx});
      nine <= 1'b0;
      per <= 16'd260;
      wr(4'h0, 32'h0000_0015);
      wr(4'h8, 32'h0000_00C3);
      wait_frames(5);
      chk("wide rate char", 32'hC3, {23'h0, rx});
      $display("test formats done");
      en <= 1'b0;
      per <= 16'd4;
      wr(4'h0, 32'h0000_000D);
      chk("inverted idle", 32'h0, {31'h0, pin.out});
      inv <= 1'b1;
      en <= 1'b1;
      @(posedge clk_i);
      wr(4'h8, 32'h0000_0096);
      wait_frames(6);
      chk("inverted char", 32'h96, {23'h0, rx});
      chk("framing", 32'h0, 32'(bad));
      en <= 1'b0;
      wr(4'h0, 32'h0000_000F);
      repeat (2) @(posedge clk_i);
      chk("clocked no invert", 32'h1, {31'h0, pin.out});
      $display("test polarity done");
      results();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      results();
   end
endmodule // testbench
